// [hdl/dwb_fifo.sv]
/*
  Shift-register FIFO with valid/ready on both sides; head entry is a flip-flop.
  Assumes the filler honours in_ready and the drain may stall at will.
*/
`timescale 1ns/1ps
module dwb_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] dat_ff [D];
  logic [W-1:0] dat_ext [D+1];
  logic [D-1:0] vld_ff;
  logic [D:0] vld_ext;
  logic [D:0] occ;
  logic push;
  logic pop;

  assign in_ready = ~vld_ff[D-1];
  assign out_valid = vld_ff[0];
  assign out_data = dat_ff[0];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign vld_ext = {1'b0, vld_ff};
  assign dat_ext[D] = '0;
  assign occ[0] = 1'b1;

  // ----------------------------------------------------------------------
  // One entry per stage: shift on pop, fill first free slot on push
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < D; i++) begin : g_entry
    logic vs;
    logic [W-1:0] ds;
    logic fill;
    assign dat_ext[i] = dat_ff[i];
    assign vs = pop ? vld_ext[i+1] : vld_ff[i];
    assign ds = pop ? dat_ext[i+1] : dat_ff[i];
    assign occ[i+1] = vs;
    assign fill = push & ~vs & occ[i];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        vld_ff[i] <= 1'b0;
        dat_ff[i] <= '0;
      end else begin
        vld_ff[i] <= vs | fill;
        dat_ff[i] <= fill ? in_data : ds;
      end
    end
  end

endmodule // dwb_fifo

// [hdl/dwb_pkg.sv]
/*
  Shared constants and carrier types of the write-burst timing block.
  Assumes a single 50 MHz clock shared by the controller, the block and the bus.
*/
package dwb_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LAT = 8'h04;
  localparam logic [7:0] ADDR_TWR = 8'h08;
  localparam logic [7:0] ADDR_TWTR = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_BL_LSB = 0;
  localparam int CTRL_DBI_BIT = 2;
  localparam int LAT_AL_LSB = 0;
  localparam int LAT_CWL_LSB = 8;
  localparam int TWR_NORM_LSB = 0;
  localparam int TWR_DBI_LSB = 8;
  localparam int TWTR_S_LSB = 0;
  localparam int TWTR_L_LSB = 8;
  localparam int TWTR_S_DBI_LSB = 16;
  localparam int TWTR_L_DBI_LSB = 24;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WREC_BIT = 1;
  localparam int STAT_WCHOP_BIT = 2;
  localparam int STAT_RCHOP_BIT = 3;
  localparam int STAT_APPEND_BIT = 4;
  localparam int STAT_PRE_EARLY_BIT = 8;
  localparam int STAT_RD_EARLY_BIT = 9;
  localparam int STAT_BEAT_LOST_BIT = 10;

  // ----------------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] CTRL_MASK = 32'h0000_0007;
  localparam logic [31:0] LAT_MASK = 32'h0000_1F1F;
  localparam logic [31:0] TWR_MASK = 32'h0000_FFFF;
  localparam logic [31:0] TWTR_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_LAT = 32'h0000_0900;
  localparam logic [31:0] RST_TWR = 32'h0000_0D0C;
  localparam logic [31:0] RST_TWTR = 32'h0703_0602;

  // ----------------------------------------------------------------------
  // Burst-length codes of mode_register_zero and burst sizes
  // ----------------------------------------------------------------------
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [2:0] BURST8_CLKS = 3'h4;
  localparam logic [2:0] BURST4_CLKS = 3'h2;
  localparam int DQ_W = 32;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {DWB_CMD_NOP, DWB_CMD_WR, DWB_CMD_RD, DWB_CMD_PRE} dwb_cmd_kind_t;

  typedef struct packed {
    dwb_cmd_kind_t kind;
    logic addr_a12;
    logic addr_a10;
    logic bg;
    logic [1:0] bank;
  } dwb_cmd_t;

  typedef struct packed {
    logic [1:0] bl;
    logic dbi;
    logic [4:0] al;
    logic [4:0] cwl;
    logic [7:0] twr;
    logic [7:0] twr_dbi;
    logic [7:0] twtr_s;
    logic [7:0] twtr_l;
    logic [7:0] twtr_s_dbi;
    logic [7:0] twtr_l_dbi;
  } dwb_cfg_t;

endpackage

// [hdl/dwb_timer.sv]
/*
  Down-counting timer: loads a cycle count and reports done when it reaches zero.
  Assumes load is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
module dwb_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [7:0] value,
  output logic [7:0] count,
  output logic done
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 8'h00;
    end else if (load) begin
      count <= value;
    end else if (count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  assign done = (count == 8'h00);

endmodule // dwb_timer

// [hdl/dwb_write_burst.sv]
/*
  Device-side write-path timing of a DDR4 SDRAM with AXI4-Lite configuration.
  Assumes command and data ports are driven by controller logic on aclk.
*/
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module dwb_write_burst (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic cmd_valid,
  input wire dwb_pkg::dwb_cmd_t cmd,
  output logic cmd_ready,
  input wire logic dq_valid,
  input wire logic [dwb_pkg::DQ_W-1:0] dq_data,
  output logic core_valid,
  input wire logic core_ready,
  output logic [dwb_pkg::DQ_W-1:0] core_data,
  output logic ap_start,
  output logic [2:0] ap_bank
);

  typedef enum logic [1:0] {ST_IDLE, ST_LAT, ST_DATA} dwb_wst_t;

  dwb_wst_t state_ff, nxt_state;
  dwb_pkg::dwb_cfg_t cfg;
  logic [31:0] reg_ctrl_ff, reg_lat_ff, reg_twr_ff, reg_twtr_ff, stat_word;
  logic [5:0] lat_ff, wl, since_ff;
  logic [2:0] beat_ff, wr_bank_ff;
  logic chop_ff, rd_chop_ff, ap_pend_ff, cmd_ready_ff, ap_start_ff;
  logic [2:0] ap_bank_ff;
  logic pre_early_ff, rd_early_ff, beat_lost_ff;
  logic cmd_take, wr_take, rd_take, pre_take, last_beat, push, fifo_in_ready, ap_fire;
  logic wr_done, wtrs_done, wtrl_done, pre_viol, rd_viol, lost;
  logic [7:0] wr_cnt, wtrs_cnt, wtrl_cnt;
  logic aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic aw_take, w_take, ar_take, aw_have, w_have, do_wr, nxt_aw_full, nxt_w_full, nxt_bvalid;
  logic nxt_rvalid;
  logic [7:0] wr_addr;
  logic [31:0] wr_word;
  logic [3:0] wr_strb;

  function automatic logic is_chop(input logic [1:0] bl, input logic a12);
    case (bl)
      dwb_pkg::BL_FIX8: is_chop = 1'b0;
      dwb_pkg::BL_OTF: is_chop = ~a12;
      dwb_pkg::BL_FIX4: is_chop = 1'b1;
      default: is_chop = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = val[8*b +: 8];
      end
    end
    merge = res & mask;
  endfunction

  // ----------------------------------------------------------------------
  // Configuration view of the register words
  // ----------------------------------------------------------------------
  assign cfg.bl = reg_ctrl_ff[dwb_pkg::CTRL_BL_LSB +: 2];
  assign cfg.dbi = reg_ctrl_ff[dwb_pkg::CTRL_DBI_BIT];
  assign cfg.al = reg_lat_ff[dwb_pkg::LAT_AL_LSB +: 5];
  assign cfg.cwl = reg_lat_ff[dwb_pkg::LAT_CWL_LSB +: 5];
  assign cfg.twr = reg_twr_ff[dwb_pkg::TWR_NORM_LSB +: 8];
  assign cfg.twr_dbi = reg_twr_ff[dwb_pkg::TWR_DBI_LSB +: 8];
  assign cfg.twtr_s = reg_twtr_ff[dwb_pkg::TWTR_S_LSB +: 8];
  assign cfg.twtr_l = reg_twtr_ff[dwb_pkg::TWTR_L_LSB +: 8];
  assign cfg.twtr_s_dbi = reg_twtr_ff[dwb_pkg::TWTR_S_DBI_LSB +: 8];
  assign cfg.twtr_l_dbi = reg_twtr_ff[dwb_pkg::TWTR_L_DBI_LSB +: 8];
  assign wl = {1'b0, cfg.al} + {1'b0, cfg.cwl};

  // ----------------------------------------------------------------------
  // Command decode and burst sequencer
  // ----------------------------------------------------------------------
  assign cmd_take = cmd_valid & cmd_ready_ff;
  assign wr_take = cmd_take & (cmd.kind == dwb_pkg::DWB_CMD_WR);
  assign rd_take = cmd_take & (cmd.kind == dwb_pkg::DWB_CMD_RD);
  assign pre_take = cmd_take & (cmd.kind == dwb_pkg::DWB_CMD_PRE);
  assign last_beat = (state_ff == ST_DATA) & (beat_ff == 3'h1);
  assign push = (state_ff == ST_DATA) & dq_valid;
  assign lost = ((state_ff == ST_DATA) & ~dq_valid) | (push & ~fifo_in_ready);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (wr_take) nxt_state = ST_LAT;
      ST_LAT: if (lat_ff <= 6'h01) nxt_state = ST_DATA;
      ST_DATA: if (beat_ff == 3'h1) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      lat_ff <= 6'h00;
      beat_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      if (wr_take) begin
        // Latency below two is clamped to two
        lat_ff <= (wl < 6'h02) ? 6'h01 : wl - 6'h01;
      end else if (state_ff == ST_LAT) begin
        lat_ff <= lat_ff - 6'h01;
      end
      if (state_ff == ST_LAT && nxt_state == ST_DATA) begin
        beat_ff <= chop_ff ? dwb_pkg::BURST4_CLKS : dwb_pkg::BURST8_CLKS;
      end else if (state_ff == ST_DATA) begin
        beat_ff <= beat_ff - 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chop_ff <= 1'b0;
      rd_chop_ff <= 1'b0;
      wr_bank_ff <= 3'h0;
      cmd_ready_ff <= 1'b0;
    end else begin
      if (wr_take) begin
        chop_ff <= is_chop(cfg.bl, cmd.addr_a12);
        wr_bank_ff <= {cmd.bg, cmd.bank};
      end
      if (rd_take) begin
        rd_chop_ff <= is_chop(cfg.bl, cmd.addr_a12);
      end
      // Hold off commands until the burst ends and the FIFO has drained
      cmd_ready_ff <= (nxt_state == ST_IDLE) & ~core_valid & ~push;
    end
  end

  // ----------------------------------------------------------------------
  // Recovery and turnaround timers, loaded at the last beat
  // ----------------------------------------------------------------------
  dwb_timer u_twr (.aclk(aclk), .aresetn(aresetn), .load(last_beat),
    .value(cfg.dbi ? cfg.twr_dbi : cfg.twr), .count(wr_cnt), .done(wr_done));
  dwb_timer u_twtr_s (.aclk(aclk), .aresetn(aresetn), .load(last_beat),
    .value(cfg.dbi ? cfg.twtr_s_dbi : cfg.twtr_s), .count(wtrs_cnt), .done(wtrs_done));
  dwb_timer u_twtr_l (.aclk(aclk), .aresetn(aresetn), .load(last_beat),
    .value(cfg.dbi ? cfg.twtr_l_dbi : cfg.twtr_l), .count(wtrl_cnt), .done(wtrl_done));

  assign pre_viol = pre_take & ({cmd.bg, cmd.bank} == wr_bank_ff) & ~wr_done;
  assign rd_viol = rd_take & ((cmd.bg == wr_bank_ff[2]) ? ~wtrl_done : ~wtrs_done);
  assign ap_fire = ap_pend_ff & (state_ff == ST_IDLE) & ~wr_take & wr_done;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ap_pend_ff <= 1'b0;
      ap_start_ff <= 1'b0;
      ap_bank_ff <= 3'h0;
    end else begin
      ap_pend_ff <= wr_take ? cmd.addr_a10 : (ap_pend_ff & ~ap_fire);
      ap_start_ff <= ap_fire;
      if (ap_fire) begin
        ap_bank_ff <= wr_bank_ff;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write data path
  // ----------------------------------------------------------------------
  dwb_fifo #(.W(dwb_pkg::DQ_W), .D(dwb_pkg::FIFO_DEPTH)) u_fifo (
    .aclk(aclk), .aresetn(aresetn), .in_valid(push), .in_ready(fifo_in_ready),
    .in_data(dq_data), .out_valid(core_valid), .out_ready(core_ready), .out_data(core_data));

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  assign aw_take = awvalid & awready_ff;
  assign w_take = wvalid & wready_ff;
  assign ar_take = arvalid & arready_ff;
  assign aw_have = aw_full_ff | aw_take;
  assign w_have = w_full_ff | w_take;
  assign do_wr = aw_have & w_have & ~bvalid_ff;
  assign nxt_aw_full = aw_have & ~do_wr;
  assign nxt_w_full = w_have & ~do_wr;
  assign nxt_bvalid = do_wr | (bvalid_ff & ~bready);
  assign nxt_rvalid = ar_take | (rvalid_ff & ~rready);
  assign wr_addr = aw_take ? awaddr : awaddr_ff;
  assign wr_word = w_take ? wdata : wdata_ff;
  assign wr_strb = w_take ? wstrb : wstrb_ff;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[dwb_pkg::STAT_BUSY_BIT] = (state_ff != ST_IDLE);
    stat_word[dwb_pkg::STAT_WREC_BIT] = ~wr_done;
    stat_word[dwb_pkg::STAT_WCHOP_BIT] = chop_ff;
    stat_word[dwb_pkg::STAT_RCHOP_BIT] = rd_chop_ff;
    stat_word[dwb_pkg::STAT_APPEND_BIT] = ap_pend_ff;
    stat_word[dwb_pkg::STAT_PRE_EARLY_BIT] = pre_early_ff;
    stat_word[dwb_pkg::STAT_RD_EARLY_BIT] = rd_early_ff;
    stat_word[dwb_pkg::STAT_BEAT_LOST_BIT] = beat_lost_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff <= nxt_w_full;
      awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
      wready_ff <= ~nxt_w_full & ~nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (aw_take) awaddr_ff <= awaddr;
      if (w_take) begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (do_wr) begin
        case (wr_addr)
          dwb_pkg::ADDR_CTRL, dwb_pkg::ADDR_LAT, dwb_pkg::ADDR_TWR, dwb_pkg::ADDR_TWTR,
          dwb_pkg::ADDR_STAT: bresp_ff <= 2'h0;
          default: bresp_ff <= 2'h2;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_ctrl_ff <= dwb_pkg::RST_CTRL;
      reg_lat_ff <= dwb_pkg::RST_LAT;
      reg_twr_ff <= dwb_pkg::RST_TWR;
      reg_twtr_ff <= dwb_pkg::RST_TWTR;
    end else if (do_wr) begin
      case (wr_addr)
        dwb_pkg::ADDR_CTRL: reg_ctrl_ff <= merge(reg_ctrl_ff, wr_word, wr_strb, dwb_pkg::CTRL_MASK);
        dwb_pkg::ADDR_LAT: reg_lat_ff <= merge(reg_lat_ff, wr_word, wr_strb, dwb_pkg::LAT_MASK);
        dwb_pkg::ADDR_TWR: reg_twr_ff <= merge(reg_twr_ff, wr_word, wr_strb, dwb_pkg::TWR_MASK);
        dwb_pkg::ADDR_TWTR: reg_twtr_ff <= merge(reg_twtr_ff, wr_word, wr_strb, dwb_pkg::TWTR_MASK);
        default: reg_ctrl_ff <= reg_ctrl_ff;
      endcase
    end
  end

  // Sticky flags: write one to clear, a new event wins over the clear
  logic clr_stat;
  assign clr_stat = do_wr & (wr_addr == dwb_pkg::ADDR_STAT) & wr_strb[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_early_ff <= 1'b0;
      rd_early_ff <= 1'b0;
      beat_lost_ff <= 1'b0;
    end else begin
      pre_early_ff <= pre_viol | (pre_early_ff &
        ~(clr_stat & wr_word[dwb_pkg::STAT_PRE_EARLY_BIT]));
      rd_early_ff <= rd_viol | (rd_early_ff &
        ~(clr_stat & wr_word[dwb_pkg::STAT_RD_EARLY_BIT]));
      beat_lost_ff <= lost | (beat_lost_ff & ~(clr_stat & wr_word[dwb_pkg::STAT_BEAT_LOST_BIT]));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= ~nxt_rvalid;
      if (ar_take) begin
        rresp_ff <= 2'h0;
        case (araddr)
          dwb_pkg::ADDR_CTRL: rdata_ff <= reg_ctrl_ff;
          dwb_pkg::ADDR_LAT: rdata_ff <= reg_lat_ff;
          dwb_pkg::ADDR_TWR: rdata_ff <= reg_twr_ff;
          dwb_pkg::ADDR_TWTR: rdata_ff <= reg_twtr_ff;
          dwb_pkg::ADDR_STAT: rdata_ff <= stat_word;
          default: begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'h2;
          end
        endcase
      end
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign cmd_ready = cmd_ready_ff;
  assign ap_start = ap_start_ff;
  assign ap_bank = ap_bank_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) since_ff <= 6'h00;
    else if (wr_take) since_ff <= 6'h01;
    else if (since_ff != 6'h3F) since_ff <= since_ff + 6'h01;
  end

  property p_bl8_fixed;
    @(posedge aclk) disable iff (!aresetn)
    (wr_take && cfg.bl == dwb_pkg::BL_FIX8) |=> !chop_ff;
  endproperty
  a_bl8_fixed: assert property (p_bl8_fixed) else $error("fixed BL8 write was chopped");

  property p_otf_bl8;
    @(posedge aclk) disable iff (!aresetn)
    (wr_take && cfg.bl == dwb_pkg::BL_OTF && cmd.addr_a12) |=> !chop_ff;
  endproperty
  a_otf_bl8: assert property (p_otf_bl8) else $error("OTF A12 high write not BL8");

  property p_otf_bc4;
    @(posedge aclk) disable iff (!aresetn)
    (wr_take && cfg.bl == dwb_pkg::BL_OTF && !cmd.addr_a12) |=> chop_ff;
  endproperty
  a_otf_bc4: assert property (p_otf_bc4) else $error("OTF A12 low write not chopped");

  property p_bc4_fixed;
    @(posedge aclk) disable iff (!aresetn)
    (rd_take && cfg.bl == dwb_pkg::BL_FIX4) |=> rd_chop_ff;
  endproperty
  a_bc4_fixed: assert property (p_bc4_fixed) else $error("fixed BC4 read not chopped");

  property p_pre_early;
    @(posedge aclk) disable iff (!aresetn)
    (pre_take && {cmd.bg, cmd.bank} == wr_bank_ff && wr_cnt != 8'h00) |=> pre_early_ff;
  endproperty
  a_pre_early: assert property (p_pre_early) else $error("early precharge not flagged");

  property p_wtr_long;
    @(posedge aclk) disable iff (!aresetn)
    (rd_take && cmd.bg == wr_bank_ff[2] && wtrl_cnt != 8'h00) |=> rd_early_ff;
  endproperty
  a_wtr_long: assert property (p_wtr_long) else $error("same-group early read not flagged");

  property p_ap_wait;
    @(posedge aclk) disable iff (!aresetn)
    ap_start_ff |-> $past(wr_cnt) == 8'h00 && $past(state_ff) == ST_IDLE;
  endproperty
  a_ap_wait: assert property (p_ap_wait) else $error("auto-precharge before recovery");

  property p_dbi_twr;
    @(posedge aclk) disable iff (!aresetn)
    (last_beat && cfg.dbi) |=> wr_cnt == $past(cfg.twr_dbi);
  endproperty
  a_dbi_twr: assert property (p_dbi_twr) else $error("DBI recovery count not used");

  property p_a10_open;
    @(posedge aclk) disable iff (!aresetn)
    (wr_take && !cmd.addr_a10) |=> !ap_pend_ff ##1 !ap_start_ff;
  endproperty
  a_a10_open: assert property (p_a10_open) else $error("A10 low write closed bank");

  property p_wl_capture;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_DATA && $past(state_ff) == ST_LAT) |->
      since_ff == ((wl < 6'h02) ? 6'h02 : wl);
  endproperty
  a_wl_capture: assert property (p_wl_capture) else $error("first beat not at WL");

  c_bl8: cover property (@(posedge aclk) disable iff (!aresetn) wr_take ##1 !chop_ff);
  c_bc4: cover property (@(posedge aclk) disable iff (!aresetn) wr_take ##1 chop_ff);
  c_ap: cover property (@(posedge aclk) disable iff (!aresetn) ap_start_ff);
  c_rd_early: cover property (@(posedge aclk) disable iff (!aresetn) rd_viol);

endmodule // dwb_write_burst

// [verification/dwb_ctl_model.sv]
/* Controller model: one command, then write words at the write latency.
   Assumes start pulses only while no command is pending. */
`timescale 1ns/1ps
module dwb_ctl_model (
  input wire logic aclk,
  input wire logic start,
  input wire dwb_pkg::dwb_cmd_t req,
  input wire logic [5:0] wl,
  input wire logic [2:0] words,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output dwb_pkg::dwb_cmd_t cmd,
  output logic dq_valid,
  output logic [31:0] dq_data
);
  int t = 99;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    dq_valid = 1'b0;
    dq_data = 32'h0;
  end
  always @(posedge aclk) begin
    if (start) begin
      cmd_valid <= 1'b1;
      cmd <= req;
    end else if (cmd_valid && cmd_ready) begin
      cmd_valid <= 1'b0;
      // Only a write starts a data window
      if (cmd.kind == dwb_pkg::DWB_CMD_WR) t = 0;
    end
    t = t + 1;
    // Idle data lines toggle: each idle cycle inverts the previous word
    dq_valid <= t >= wl && t < wl + words;
    dq_data <= (t >= wl && t < wl + words) ? 32'h5A00_0000 + t : ~dq_data;
  end
endmodule // dwb_ctl_model

// [verification/dwb_write_burst_bench.sv]
/* Bench: register set-up, burst sizes, latency and auto-precharge timing.
   Assumes dwb_ctl_model is compiled before it. */
`timescale 1ns/1ps
module dwb_write_burst_bench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, cmd_valid, cmd_ready, dq_valid, core_valid;
  logic ap_start, start = 0, core_ready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, dq_data, core_data;
  logic [1:0] bresp, rresp;
  logic [2:0] ap_bank, words = 3'h0;
  logic [5:0] wl = 6'h00;
  dwb_pkg::dwb_cmd_t cmd, req = '0;
  int n_errors = 0, tests_run = 0;
  always #10 aclk = ~aclk;
  always @(posedge aclk) core_ready <= ~core_ready;
  dwb_write_burst i_dwb_write_burst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .dq_valid(dq_valid), .dq_data(dq_data), .core_valid(core_valid), .core_ready(core_ready),
    .core_data(core_data), .ap_start(ap_start), .ap_bank(ap_bank));
  dwb_ctl_model i_dwb_ctl_model (.aclk(aclk), .start(start), .req(req), .wl(wl),
    .words(words), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd(cmd),
    .dq_valid(dq_valid), .dq_data(dq_data));
  task automatic conclude();
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stall(input int k);
    if (k >= 200) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    stall(k);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    stall(k);
  endtask
  // One command through the controller model; returns at the edge that takes it
  task automatic issue(input dwb_pkg::dwb_cmd_kind_t kd, input logic a12, a10, bg,
      input logic [1:0] bk);
    int k;
    req <= '{kd, a12, a10, bg, bk};
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    for (k = 0; k < 200 && !(cmd_valid && cmd_ready); k++) @(posedge aclk);
    stall(k);
  endtask
  // One write burst: words delivered and edge of internal precharge
  task automatic run_case(input logic [31:0] ctrl, lat, input logic a12, a10,
      input logic [5:0] w, input int n, twr);
    int k, got, ap;
    logic [31:0] d;
    logic [1:0] r;
    got = 0;
    ap = 0;
    axi_wr(dwb_pkg::ADDR_CTRL, ctrl);
    axi_wr(dwb_pkg::ADDR_LAT, lat);
    wl <= w;
    words <= n[2:0];
    issue(dwb_pkg::DWB_CMD_WR, a12, a10, 1'b0, 2'h1);
    for (k = 1; k <= 60; k++) begin
      @(posedge aclk);
      if (core_valid && core_ready) got++;
      if (ap_start) ap = k;
    end
    chk("burst words", got, n);
    chk("precharge edge", ap, a10 ? w + n + twr + 1 : 0);
    axi_rd(dwb_pkg::ADDR_STAT, d, r);
    chk("chop and lost", {d[10], d[2]}, {1'b0, n == 2});
  endtask
  // Early precharge and same-group read flagged; other group and on-time ones not
  task automatic cmd_rules();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(dwb_pkg::ADDR_TWTR, 32'h0703_3002);
    issue(dwb_pkg::DWB_CMD_WR, 1'b1, 1'b0, 1'b0, 2'h1);
    issue(dwb_pkg::DWB_CMD_RD, 1'b1, 1'b0, 1'b1, 2'h0);
    issue(dwb_pkg::DWB_CMD_PRE, 1'b0, 1'b0, 1'b0, 2'h1);
    axi_rd(dwb_pkg::ADDR_STAT, d, r);
    chk("early precharge", d[10:8], 3'h1);
    issue(dwb_pkg::DWB_CMD_RD, 1'b1, 1'b0, 1'b0, 2'h0);
    axi_rd(dwb_pkg::ADDR_STAT, d, r);
    chk("early same-group read", d[10:8], 3'h3);
    axi_wr(dwb_pkg::ADDR_STAT, 32'h0000_0700);
    repeat (50) @(posedge aclk);
    issue(dwb_pkg::DWB_CMD_PRE, 1'b0, 1'b0, 1'b0, 2'h1);
    issue(dwb_pkg::DWB_CMD_RD, 1'b1, 1'b0, 1'b0, 2'h0);
    axi_rd(dwb_pkg::ADDR_STAT, d, r);
    chk("on-time commands", d[10:8], 3'h0);
  endtask
  // Reset value and unmapped-address response
  task automatic reg_defaults();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(dwb_pkg::ADDR_LAT, d, r);
    chk("lat reset", d, dwb_pkg::RST_LAT);
    axi_rd(8'h20, d, r);
    chk("unmapped resp", {30'h0, r}, 32'h2);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    reg_defaults();
    run_case(32'h0, dwb_pkg::RST_LAT, 1'b0, 1'b1, 6'h09, 4, dwb_pkg::RST_TWR[7:0]);
    run_case(32'h1, dwb_pkg::RST_LAT, 1'b1, 1'b1, 6'h09, 4, dwb_pkg::RST_TWR[7:0]);
    run_case(32'h1, dwb_pkg::RST_LAT, 1'b0, 1'b1, 6'h09, 2, dwb_pkg::RST_TWR[7:0]);
    run_case(32'h2, dwb_pkg::RST_LAT, 1'b1, 1'b1, 6'h09, 2, dwb_pkg::RST_TWR[7:0]);
    run_case(32'h5, dwb_pkg::RST_LAT, 1'b1, 1'b1, 6'h09, 4, dwb_pkg::RST_TWR[15:8]);
    run_case(32'h0, 32'h0902, 1'b1, 1'b0, 6'h0B, 4, dwb_pkg::RST_TWR[7:0]);
    cmd_rules();
    conclude();
  end
endmodule // dwb_write_burst_bench
